// ===== scb_pkg.sv
// Shared constants, types and the frame check function of the SPI target
package scb_pkg;
    // Frame layout
    localparam int unsigned SCB_FRAME_BITS = 32;
    localparam int unsigned SCB_BURST_BITS = 24;
    localparam int unsigned SCB_PAY_BITS   = 24;
    localparam int unsigned SCB_ADDR_W     = 7;
    localparam int unsigned SCB_DATA_W     = 16;
    localparam int unsigned SCB_CRC_W      = 8;
    localparam int unsigned SCB_NREG       = 128;
    localparam int unsigned SCB_WR_W       = 24;
    localparam int unsigned SCB_CNT_W      = 6;
    localparam logic [5:0]  SCB_CNT_MAX    = 6'h3f;
    localparam logic [5:0]  SCB_CNT_FRAME  = 6'h20;
    localparam logic [5:0]  SCB_CNT_BURST  = 6'h18;
    localparam logic [5:0]  SCB_CNT_LAST   = 6'h01;
    // Frame check sequence x^8+x^2+x+1
    localparam logic [7:0]  SCB_CRC_POLY   = 8'h07;
    localparam logic [7:0]  SCB_CRC_INIT   = 8'h00;
    // Read-selection register and its fields
    localparam logic [7:0]  SCB_RDSEL_ADDR = 8'h64;
    localparam int unsigned SCB_RDSEL_INFO = 8;
    localparam int unsigned SCB_RDSEL_AUTO = 9;
    localparam logic [6:0]  SCB_RBADDR_RST = 7'h00;
    // Synchronised pin positions
    localparam int unsigned SCB_PIN_SCLK   = 0;
    localparam int unsigned SCB_PIN_SYNC   = 1;
    localparam int unsigned SCB_PIN_SDI    = 2;
    localparam logic [2:0]  SCB_PIN_RST    = 3'h2;
    // Write FIFO
    localparam int unsigned SCB_FIFO_DEPTH = 16;

    typedef enum logic {SCB_IDLE, SCB_FRAME} scb_state_t;

    // MSB-first CRC over 24 payload bits, zero start, no inversion
    function automatic logic [7:0] scb_crc8(input logic [23:0] d);
        logic [7:0] c;
        c = SCB_CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            if (c[7] ^ d[i]) begin
                c = {c[6:0], 1'b0} ^ SCB_CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction : scb_crc8
endpackage : scb_pkg

// ===== scb_stream_if.sv
// Valid/ready word stream between the SPI target and its write FIFO
interface scb_stream_if #(parameter int unsigned W = 24);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : scb_stream_if

// ===== scb_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
module scb_fifo #(
    parameter int unsigned WIDTH = 24,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    scb_stream_if.snk in_s,
    scb_stream_if.src out_s
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_idx_r;
    logic [AW-1:0]    rd_idx_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    // Honest full and empty from the fill count
    assign in_s.ready  = (cnt_r != FULL_CNT);
    assign out_s.valid = (cnt_r != '0);
    assign out_s.data  = mem_r[rd_idx_r];
    assign push        = in_s.valid & in_s.ready;
    assign pop         = out_s.valid & out_s.ready;

    // Storage, written at the tail
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_idx_r] <= in_s.data;
        end
    end

    // Pointers and count; depth is a power of two so indices wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_idx_r <= '0;
            rd_idx_r <= '0;
            cnt_r    <= '0;
        end else begin
            if (push) begin
                wr_idx_r <= wr_idx_r + 1'b1;
            end
            if (pop) begin
                rd_idx_r <= rd_idx_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule : scb_fifo

// ===== scb_spi_target.sv
// SPI target with CRC-checked writes, auto readback and burst readback
module scb_spi_target #(
    parameter logic [6:0]  MODEM_RX_ADDR = 7'h00,
    parameter int unsigned FIFO_DEPTH    = scb_pkg::SCB_FIFO_DEPTH
) (
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire logic                           sclk,
    input  wire logic                           sync_n,
    input  wire logic                           sdi,
    output logic                                sdo,
    output logic                                sdo_oe,
    output logic                                alert_n,
    output logic                                spi_err,
    input  wire logic                           spi_err_clr,
    input  wire logic                           alert_mask,
    input  wire logic                           other_alert,
    input  wire logic [scb_pkg::SCB_ADDR_W-1:0] status_info,
    input  wire logic [scb_pkg::SCB_NREG-1:0]   burst_sel,
    output logic [scb_pkg::SCB_ADDR_W-1:0]      rd_addr,
    input  wire logic [scb_pkg::SCB_DATA_W-1:0] rd_data,
    output logic                                wr_valid,
    input  wire logic                           wr_ready,
    output logic [7:0]                          wr_addr,
    output logic [scb_pkg::SCB_DATA_W-1:0]      wr_data,
    output logic                                auto_read_en,
    output logic                                return_info_select,
    output logic [scb_pkg::SCB_ADDR_W-1:0]      readback_addr
);
    import scb_pkg::*;

    // Pin synchronisers and filtered levels
    logic [2:0]            s1_r;
    logic [2:0]            s2_r;
    logic [2:0]            s3_r;
    logic [2:0]            pin_r;
    logic [2:0]            pin_nxt;
    logic [2:0]            agree;
    // Frame tracking
    scb_state_t            st_r;
    logic [SCB_CNT_W-1:0]  fall_cnt_r;
    logic [SCB_CNT_W-1:0]  rise_cnt_r;
    logic [SCB_CNT_W-1:0]  left_r;
    logic                  burst_r;
    logic                  hold_r;
    logic [31:0]           rx_r;
    logic [31:0]           tx_r;
    logic                  oe_r;
    // Readback state
    logic [SCB_ADDR_W-1:0] ptr_r;
    logic [SCB_DATA_W-1:0] rdq_r;
    logic [SCB_ADDR_W-1:0] rb_addr_r;
    logic                  info_r;
    logic                  auto_r;
    logic                  pend_r;
    // Error and alert
    logic                  err_r;
    logic                  alert_n_r;
    // Write path into the FIFO
    logic                  push_valid_r;
    logic [SCB_WR_W-1:0]   push_data_r;
    // Registered write head towards the sink
    logic                  head_valid_r;
    logic [SCB_WR_W-1:0]   head_data_r;

    logic                  sync_fall;
    logic                  sync_rise;
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  frame_end;
    logic                  armed;
    logic [SCB_DATA_W-1:0] rdsel_val;
    logic [SCB_DATA_W-1:0] data16;
    logic [SCB_ADDR_W-1:0] info7;
    logic [23:0]           hdr24;
    logic [7:0]            tx_crc;
    logic [SCB_ADDR_W-1:0] ptr_next;
    logic                  hold_now;
    logic                  crc_ok;
    logic                  len_ok;
    logic                  burst_ok;
    logic                  wr_good;
    logic                  to_rdsel;
    logic                  push_busy;
    logic                  frame_err;

    scb_stream_if #(.W(SCB_WR_W)) fifo_in ();
    scb_stream_if #(.W(SCB_WR_W)) fifo_out ();

    // Three-stage pin capture; a change counts once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r  <= SCB_PIN_RST;
            s2_r  <= SCB_PIN_RST;
            s3_r  <= SCB_PIN_RST;
            pin_r <= SCB_PIN_RST;
        end else begin
            s1_r  <= {sdi, sync_n, sclk};
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            pin_r <= pin_nxt;
        end
    end

    assign agree   = ~(s2_r ^ s3_r);
    assign pin_nxt = (s3_r & agree) | (pin_r & ~agree);

    // Edge events of the filtered pins
    assign sync_fall = pin_r[SCB_PIN_SYNC] & ~pin_nxt[SCB_PIN_SYNC];
    assign sync_rise = ~pin_r[SCB_PIN_SYNC] & pin_nxt[SCB_PIN_SYNC];
    assign sclk_rise = (st_r == SCB_FRAME) & ~pin_r[SCB_PIN_SCLK]
                     & pin_nxt[SCB_PIN_SCLK];
    assign sclk_fall = (st_r == SCB_FRAME) & pin_r[SCB_PIN_SCLK]
                     & ~pin_nxt[SCB_PIN_SCLK];
    assign frame_end = (st_r == SCB_FRAME) & sync_rise;

    // Readback word built from the current pointer
    assign armed     = auto_r | pend_r;
    assign rdsel_val = {6'h00, auto_r, info_r, 1'b0, rb_addr_r};
    always_comb begin
        if (!armed) begin
            data16 = '0;
        end else if (ptr_r == SCB_RDSEL_ADDR[SCB_ADDR_W-1:0]) begin
            data16 = rdsel_val;
        end else begin
            data16 = rdq_r;
        end
    end
    assign info7  = info_r ? status_info : ptr_r;
    assign hdr24  = {1'b1, info7, data16};
    assign tx_crc = scb_crc8(hdr24);

    // Next burst address: skip deselected, stay on the modem receive register
    function automatic logic [SCB_ADDR_W-1:0] next_addr(
        input logic [SCB_ADDR_W-1:0] p,
        input logic                  hold,
        input logic [SCB_NREG-1:0]   sel
    );
        logic [SCB_ADDR_W-1:0] r;
        logic [SCB_ADDR_W-1:0] c;
        logic                  found;
        r     = p;
        found = 1'b0;
        if (!hold) begin
            for (int k = 1; k < SCB_NREG; k++) begin
                c = p + SCB_ADDR_W'(k);
                if (!found && sel[c]) begin
                    r     = c;
                    found = 1'b1;
                end
            end
        end
        return r;
    endfunction : next_addr

    // Hold is judged on the start register at frame-sync fall, not stale
    assign hold_now = sync_fall ? (ptr_r == MODEM_RX_ADDR) : hold_r;
    assign ptr_next = next_addr(ptr_r, hold_now, burst_sel);

    // Frame checks at the rising frame-sync edge
    assign crc_ok    = (scb_crc8(rx_r[31:8]) == rx_r[7:0]);
    assign len_ok    = (fall_cnt_r == SCB_CNT_FRAME);
    assign burst_ok  = (left_r == SCB_CNT_BURST)
                     & (rise_cnt_r == SCB_CNT_FRAME);
    assign wr_good   = ~burst_r & len_ok & crc_ok;
    assign to_rdsel  = (rx_r[31:24] == SCB_RDSEL_ADDR);
    assign push_busy = push_valid_r & ~fifo_in.ready;
    assign frame_err = burst_r ? ~burst_ok
                     : (~wr_good | (~to_rdsel & push_busy));

    // Frame state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= SCB_IDLE;
        end else begin
            case (st_r)
                SCB_IDLE: begin
                    if (sync_fall) begin
                        st_r <= SCB_FRAME;
                    end
                end
                SCB_FRAME: begin
                    if (sync_rise) begin
                        st_r <= SCB_IDLE;
                    end
                end
                default: begin
                    st_r <= SCB_IDLE;
                end
            endcase
        end
    end

    // Receive shifter and falling-edge count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_r       <= '0;
            fall_cnt_r <= '0;
        end else if (sync_fall) begin
            fall_cnt_r <= '0;
        end else if (sclk_fall) begin
            rx_r <= {rx_r[30:0], pin_nxt[SCB_PIN_SDI]};
            if (fall_cnt_r != SCB_CNT_MAX) begin
                fall_cnt_r <= fall_cnt_r + 1'b1;
            end
        end
    end

    // Transmit shifter, rising-edge count and burst word loads
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_r       <= '0;
            rise_cnt_r <= '0;
            left_r     <= '0;
            burst_r    <= 1'b0;
            hold_r     <= 1'b0;
        end else if (sync_fall) begin
            tx_r       <= {hdr24, tx_crc};
            rise_cnt_r <= '0;
            left_r     <= SCB_CNT_FRAME;
            burst_r    <= 1'b0;
            hold_r     <= (ptr_r == MODEM_RX_ADDR);
        end else if (sclk_rise) begin
            if (rise_cnt_r == SCB_CNT_FRAME) begin
                burst_r <= 1'b1;
            end else begin
                rise_cnt_r <= rise_cnt_r + 1'b1;
            end
            if (left_r == SCB_CNT_LAST) begin
                tx_r   <= {data16, tx_crc, 8'h00};
                left_r <= SCB_CNT_BURST;
            end else begin
                tx_r   <= {tx_r[30:0], 1'b0};
                left_r <= left_r - 1'b1;
            end
        end
    end

    // Output drive enable follows frame-sync
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_r <= 1'b0;
        end else if (sync_fall) begin
            oe_r <= 1'b1;
        end else if (sync_rise) begin
            oe_r <= 1'b0;
        end
    end

    // Readback pointer and captured register data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_r <= SCB_RBADDR_RST;
            rdq_r <= '0;
        end else begin
            rdq_r <= rd_data;
            if (frame_end) begin
                if (wr_good && to_rdsel) begin
                    ptr_r <= rx_r[8 +: SCB_ADDR_W];
                end else begin
                    ptr_r <= rb_addr_r;
                end
            end else if (sync_fall) begin
                ptr_r <= ptr_next;
            end else if (sclk_rise && left_r == SCB_CNT_LAST) begin
                ptr_r <= ptr_next;
            end
        end
    end

    // Read-selection register and the one-frame read request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rb_addr_r <= SCB_RBADDR_RST;
            info_r    <= 1'b0;
            auto_r    <= 1'b0;
            pend_r    <= 1'b0;
        end else if (frame_end) begin
            if (wr_good && to_rdsel) begin
                rb_addr_r <= rx_r[8 +: SCB_ADDR_W];
                info_r    <= rx_r[8 + SCB_RDSEL_INFO];
                auto_r    <= rx_r[8 + SCB_RDSEL_AUTO];
                pend_r    <= 1'b1;
            end else begin
                pend_r <= 1'b0;
            end
        end
    end

    // Good writes to other registers go to the FIFO
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            push_valid_r <= 1'b0;
            push_data_r  <= '0;
        end else if (frame_end && wr_good && !to_rdsel && !push_busy) begin
            push_valid_r <= 1'b1;
            push_data_r  <= rx_r[31:8];
        end else if (fifo_in.ready) begin
            push_valid_r <= 1'b0;
        end
    end

    // Sticky SPI error; a new error wins over a clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_r <= 1'b0;
        end else if (frame_end && frame_err) begin
            err_r <= 1'b1;
        end else if (spi_err_clr) begin
            err_r <= 1'b0;
        end
    end

    // Alert pin, low while any unmasked alert stands
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_n_r <= 1'b1;
        end else begin
            alert_n_r <= ~((err_r & ~alert_mask) | other_alert);
        end
    end

    assign fifo_in.valid  = push_valid_r;
    assign fifo_in.data   = push_data_r;
    assign fifo_out.ready = ~head_valid_r | wr_ready;

    // Head register refills every cycle the sink takes or it is empty
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head_valid_r <= 1'b0;
            head_data_r  <= '0;
        end else if (fifo_out.ready) begin
            head_valid_r <= fifo_out.valid;
            if (fifo_out.valid) begin
                head_data_r <= fifo_out.data;
            end
        end
    end

    scb_fifo #(
        .WIDTH (SCB_WR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk   (clk),
        .rst_n (rst_n),
        .in_s  (fifo_in),
        .out_s (fifo_out)
    );

    // Port drive
    assign sdo                = tx_r[31];
    assign sdo_oe             = oe_r;
    assign alert_n            = alert_n_r;
    assign spi_err            = err_r;
    assign rd_addr            = ptr_r;
    assign wr_valid           = head_valid_r;
    assign wr_addr            = head_data_r[23:16];
    assign wr_data            = head_data_r[15:0];
    assign auto_read_en       = auto_r;
    assign return_info_select = info_r;
    assign readback_addr      = rb_addr_r;
endmodule : scb_spi_target

// ===== scb_spi_target_chk.sv
// Assertion checker bound to the SPI target top
module scb_spi_target_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        sync_n,
    input wire logic        sdo,
    input wire logic        sdo_oe,
    input wire logic        alert_n,
    input wire logic        spi_err,
    input wire logic        spi_err_clr,
    input wire logic        alert_mask,
    input wire logic        other_alert,
    input wire logic        wr_valid,
    input wire logic        wr_ready,
    input wire logic [7:0]  wr_addr,
    input wire logic [15:0] wr_data
);
    // One clock domain, reset disables all checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_oe_on;
        $fell(sync_n) |-> ##[1:7] sdo_oe;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("sdo_oe late after frame start");
    property p_oe_off;
        $rose(sync_n) |-> ##[1:7] !sdo_oe;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("sdo_oe held after frame end");
    property p_msb;
        $rose(sdo_oe) |-> ##[0:1] sdo;
    endproperty
    a_msb: assert property (p_msb)
        else $error("first output bit not one");
    property p_alert;
        1'b1 |=> alert_n == !($past(spi_err && !alert_mask) || $past(other_alert));
    endproperty
    a_alert: assert property (p_alert)
        else $error("alert pin does not follow error and mask");
    property p_clr;
        spi_err_clr && sync_n && $past(sync_n, 8) && !sdo_oe |=> !spi_err;
    endproperty
    a_clr: assert property (p_clr)
        else $error("error flag not cleared");
    property p_sticky;
        spi_err && !spi_err_clr |=> spi_err;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("error flag dropped without clear");
    property p_err_end;
        $rose(spi_err) |-> sync_n && !sdo_oe;
    endproperty
    a_err_end: assert property (p_err_end)
        else $error("error flag set inside a frame");
    property p_push_end;
        $rose(wr_valid) |-> sync_n && !sdo_oe;
    endproperty
    a_push_end: assert property (p_push_end)
        else $error("write pushed inside a frame");
    property p_hold;
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("write head changed while stalled");
endmodule : scb_spi_target_chk

bind scb_spi_target scb_spi_target_chk u_chk (
    .clk(clk), .rst_n(rst_n), .sync_n(sync_n), .sdo(sdo), .sdo_oe(sdo_oe),
    .alert_n(alert_n), .spi_err(spi_err), .spi_err_clr(spi_err_clr),
    .alert_mask(alert_mask), .other_alert(other_alert),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data)
);

// ===== scb_host_model.sv
// SPI host model: frames, bursts and frame check sequences
module scb_host_model (
    output logic     sclk,
    output logic     sync_n,
    output logic     sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [103:0] rx;
    // Idle: clock stands low, frame-sync high
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        sdi = 1'b1;
    end
    // MSB-first check sequence, zero start, no inversion
    function automatic logic [7:0] crc(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : crc
    // Frame of n clocks, w sent MSB first, sdo gathered into rx
    task automatic xfer(input logic [31:0] w, input int n);
        sync_n = 1'b0;
        #83;
        for (int i = 0; i < n; i++) begin
            sdi = (i < 32) ? w[31-i] : ~sdi;
            rx = {rx[102:0], sdo}; // Sampled before rising edge
            sclk = 1'b1;
            #80;
            sclk = 1'b0;
            #80;
        end
        sync_n = 1'b1;
        sdi = ~sdi; // Released line shows no stale bit
        #150;
    endtask : xfer
    // Write frame with check sequence, bad flips check bits
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      input logic [7:0] bad);
        xfer({a, d, crc({a, d}) ^ bad}, 32);
    endtask : wr
endmodule : scb_host_model

// ===== scb_spi_target_bench.sv
// Self-checking bench of the SPI target with a host model
module scb_spi_target_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import scb_pkg::*;
    localparam logic [6:0] MODEM = 7'h10;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         sclk, sync_n, sdi, sdo, sdo_oe, alert_n, spi_err;
    logic         spi_err_clr = 1'b0;
    logic         alert_mask = 1'b0;
    logic         other_alert = 1'b0;
    logic         wr_ready = 1'b0;
    logic [6:0]   status_info;
    logic [127:0] burst_sel;
    logic [6:0]   rd_addr, rb_addr, a;
    logic [15:0]  rd_data, wr_data;
    logic [7:0]   wr_addr;
    logic         wr_valid, auto_read_en, info_sel;
    logic [7:0]   wa [16];
    logic [15:0]  wd [16];
    int           lens [3] = '{31, 33, 8};
    int           n_errors = 0;
    int           n_compared = 0;
    int           seed = 16369;
    int           cycles = 0;

    scb_host_model host (.sclk(sclk), .sync_n(sync_n), .sdi(sdi),
                         .sdo(sdo));
    scb_spi_target #(.MODEM_RX_ADDR(MODEM), .FIFO_DEPTH(16)) DUT (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .alert_n(alert_n), .spi_err(spi_err),
        .spi_err_clr(spi_err_clr), .alert_mask(alert_mask),
        .other_alert(other_alert), .status_info(status_info),
        .burst_sel(burst_sel), .rd_addr(rd_addr), .rd_data(rd_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
        .wr_data(wr_data), .auto_read_en(auto_read_en),
        .return_info_select(info_sel), .readback_addr(rb_addr));

    // Clock and register file contents
    always #5 clk = ~clk;
    assign rd_data = regval(rd_addr);

    function automatic logic [15:0] regval(input logic [6:0] q);
        return {q ^ 7'h5a, 2'h1, ~q};
    endfunction : regval
    // Next selected address in a burst
    function automatic logic [6:0] step(input logic [6:0] q);
        logic [6:0] r;
        r = q;
        for (int i = 0; i < 127; i++) begin
            r = r + 7'h01;
            if (burst_sel[r]) begin
                return r;
            end
        end
        return q;
    endfunction : step
    // Readback word with its check sequence
    function automatic logic [31:0] rbw(input logic [6:0] q,
                                        input logic [6:0] info);
        logic [23:0] d;
        d = {1'b1, info, regval(q)};
        return {d, host.crc(d)};
    endfunction : rbw
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Write-1 pulse on the error flag
    task automatic clr();
        tick(1);
        spi_err_clr = 1'b1;
        tick(1);
        spi_err_clr = 1'b0;
        tick(3);
        check(spi_err, 1'b0);
        check(alert_n, 1'b1);
    endtask : clr
    task automatic rsel(input logic [6:0] q, input logic inf, input logic au);
        host.wr(SCB_RDSEL_ADDR, {6'h00, au, inf, 1'b0, q}, 8'h00);
        check(rb_addr, q);
        check(info_sel, inf);
        check(auto_read_en, au);
    endtask : rsel
    // Burst of n extra registers from q, frame-sync held low
    task automatic burst(input logic [6:0] q, input int n);
        int w;
        logic [6:0] p;
        w = 32 + 24 * n;
        p = q;
        host.xfer(32'h0, w);
        check(host.rx[w-1 -: 32], rbw(p, p));
        for (int j = 1; j <= n; j++) begin
            p = (q == MODEM) ? p : step(p);
            check(host.rx[w-9-24*j -: 24], rbw(p, p) & 32'hffffff);
        end
        check(spi_err, 1'b0);
        check(wr_valid, 1'b0);
    endtask : burst
    task automatic summarize();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            summarize();
        end
    end

    // Main sequence
    initial begin
        status_info = 7'($random(seed));
        burst_sel = {$random(seed), $random(seed), $random(seed), $random(seed)};
        burst_sel[MODEM] = 1'b0;
        burst_sel[SCB_RDSEL_ADDR[6:0]] = 1'b0;
        tick(12);
        rst_n = 1'b1;
        tick(4);
        check(alert_n, 1'b1);
        host.wr(8'h12, 16'h3456, 8'h80); // Corrupt top check bit
        check(spi_err, 1'b1);
        check(alert_n, 1'b0);
        check(wr_valid, 1'b0);
        tick(1);
        alert_mask = 1'b1;
        tick(2);
        check(alert_n, 1'b1);
        other_alert = 1'b1;
        tick(2);
        check(alert_n, 1'b0);
        other_alert = 1'b0;
        alert_mask = 1'b0;
        clr();
        foreach (lens[k]) begin
            host.xfer({24'h123456, host.crc(24'h123456)}, lens[k]);
            check(spi_err, 1'b1);
            check(wr_valid, 1'b0);
            clr();
        end
        for (int i = 0; i < 16; i++) begin
            wa[i] = (i == 0) ? 8'hff : {2'b00, 6'($random(seed))};
            wd[i] = 16'($random(seed));
            host.wr(wa[i], wd[i], 8'h00);
        end
        check(spi_err, 1'b0);
        tick(1);
        wr_ready = 1'b1;
        for (int i = 0; i < 16; i++) begin
            check(wr_valid, 1'b1);
            check({wr_addr, wr_data}, {wa[i], wd[i]});
            tick(1);
        end
        check(wr_valid, 1'b0);
        for (int k = 0; k < 2; k++) begin
            a = 7'($random(seed)) & 7'h3f;
            rsel(a, k[0], 1'b0);
            host.wr(8'h00, 16'h0000, 8'h00);
            check(host.rx[31:0], rbw(a, k[0] ? status_info : a));
        end
        // Reading the read-selection register returns its own fields
        rsel(7'h64, 1'b1, 1'b0);
        host.wr(8'h00, 16'h0000, 8'h00);
        check(host.rx[31:0], {1'b1, status_info, 16'h0164,
              host.crc({1'b1, status_info, 16'h0164})});
        rsel(7'h2a, 1'b0, 1'b1);
        repeat (2) begin
            host.wr(8'h01, 16'($random(seed)), 8'h00);
            check(host.rx[31:0], rbw(7'h2a, 7'h2a));
        end
        tick(1);
        wr_ready = 1'b0;
        for (int n = 1; n <= 3; n++) begin
            a = 7'($random(seed)) & 7'h3f;
            rsel(a, 1'b0, 1'b1);
            burst(a, n);
        end
        rsel(MODEM, 1'b0, 1'b1);
        burst(MODEM, 2);
        host.xfer(32'h0, 61); // Five clocks into a second burst word
        check(spi_err, 1'b1);
        clr();
        summarize();
    end
endmodule : scb_spi_target_bench
